// ### design/reset_combiner_regs.vh
`ifndef RESET_COMBINER_REGS_VH
`define RESET_COMBINER_REGS_VH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define OFS_CAUSE_STATUS 12'h000
`define OFS_CONTROL 12'h004
`define OFS_TIMERS 12'h008
// ----------------------------------------
// cause/status field positions
// ----------------------------------------
`define BIT_TRAP 15
`define BIT_ILLEGAL 14
`define BIT_DEEP_SLEEP 10
`define BIT_MISMATCH 9
`define BIT_PM_SLEEP 8
`define BIT_PIN 7
`define BIT_INSTR 6
`define BIT_WDT_EN 5
`define BIT_WDT_TO 4
`define BIT_SLEEP 3
`define BIT_IDLE 2
`define BIT_BROWNOUT 1
`define BIT_POWERON 0
// implemented bits; 13..11 always read zero
`define CAUSE_MASK 16'hC7FF
`define CAUSE_POR_VALUE 16'h0003
// ----------------------------------------
// release delays, clock period and axi response codes
// ----------------------------------------
`define POWERON_DELAY_NS 1000
`define POWERUP_TIMER_NS 2000
`define CLK_PERIOD_NS 20
`define AXI_OKAY 2'h0
`define AXI_DECERR 2'h3
`endif

// ### design/reset_source_combiner_status.v
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "reset_combiner_regs.vh"

// Operation
// - any active source asserts master reset
// - nine reset sources are accepted
// - each reset kind sets its flag
// - power-on clears all but bits one, zero
// - software sets or clears flags, no reset
// - untouched state survives non power-on resets
// - trap flag bit 15 set by trap reset
// - illegal flag bit 14 on opcode/wreg faults
// - bits 13 to 11 read zero
// - deep sleep flag, software clear only
// - mismatch flag bit 9 on mismatch reset
// - progmem sleep power bit drives bias
// - pin reset flag bit 7
// - instruction reset flag bit 6
// - watchdog enable, fuse forces on
// - watchdog timeout flag, cleared by powersave
// - sleep and idle flags on powersave
// - brownout flag on brownout or power-on
// - power-on flag only on power-on
// - release after both power delays expire, after power events only
module reset_source_combiner_status #(
    parameter PON_CYCLES =
        (`POWERON_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter POWER_UP_TIMER_CYCLES =
        (`POWERUP_TIMER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input wire mclk,
    input wire rst,
    input wire powerOnReset,
    input wire brownoutReset,
    input wire masterClearPin,
    input wire resetInstruction,
    input wire watchdogTimeout,
    input wire configMismatch,
    input wire trapConflict,
    input wire illegalOpcode,
    input wire uninitWregReset,
    input wire sleepInstruction,
    input wire idleInstruction,
    input wire deepSleepEnable,
    input wire watchdogFuseEnable,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg masterSystemReset,
    output reg watchdogEnable,
    output reg progmemBiasOn,
    output reg regulatorStandby
);

// ----------------------------------------
// reset source combining
// ----------------------------------------
wire anySource = powerOnReset | brownoutReset | masterClearPin |
    resetInstruction | watchdogTimeout | configMismatch |
    trapConflict | illegalOpcode | uninitWregReset;
wire powerSource = powerOnReset | brownoutReset;

// ----------------------------------------
// release sequencing
// ----------------------------------------
// delay phases: power-on delay, then power-up timer
// a new source in any phase drops back to hold, so a glitching source
// restarts the whole release instead of shortening it
localparam PH_HOLD = 3'b001;
localparam PH_PON = 3'b010;
localparam PH_POWER_UP_TIMER = 3'b100;

reg [2:0] phase_r;
reg [2:0] phase_nxt;
reg [15:0] delay_r;
reg [15:0] delay_nxt;
reg powerEvent_r;
reg powerEvent_nxt;

// shared down-count step of both delay phases
function [15:0] decr;
    input [15:0] v;
    begin
        decr = v - 16'h0001;
    end
endfunction

always @* begin
    phase_nxt = phase_r;
    delay_nxt = delay_r;
    powerEvent_nxt = powerEvent_r | powerSource;
    case (phase_r)
        PH_HOLD: begin
            if (!anySource) begin
                // only power events pay the long release delays
                if (powerEvent_r) begin
                    phase_nxt = PH_PON;
                    delay_nxt = PON_CYCLES[15:0];
                end else begin
                    phase_nxt = PH_POWER_UP_TIMER;
                    delay_nxt = 16'h0000;
                end
            end
        end
        PH_PON: begin
            if (anySource) begin
                phase_nxt = PH_HOLD;
            end else if (delay_r <= 16'h0001) begin
                phase_nxt = PH_POWER_UP_TIMER;
                delay_nxt = POWER_UP_TIMER_CYCLES[15:0];
            end else begin
                delay_nxt = decr(delay_r);
            end
        end
        PH_POWER_UP_TIMER: begin
            if (anySource) begin
                phase_nxt = PH_HOLD;
            end else if (delay_r > 16'h0000) begin
                delay_nxt = decr(delay_r);
            end else begin
                powerEvent_nxt = 1'b0;
            end
        end
        default: begin
            phase_nxt = PH_HOLD;
        end
    endcase
end

wire released = (phase_nxt == PH_POWER_UP_TIMER) && (delay_nxt == 16'h0000) &&
    !anySource;

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        phase_r <= PH_HOLD;
        delay_r <= 16'h0000;
        powerEvent_r <= 1'b1;
        masterSystemReset <= 1'b1;
    end else begin
        phase_r <= phase_nxt;
        delay_r <= delay_nxt;
        powerEvent_r <= powerEvent_nxt;
        masterSystemReset <= !released;
    end
end

// ----------------------------------------
// cause/status register
// ----------------------------------------
reg [15:0] cause_r;
reg [15:0] cause_nxt;
reg [15:0] hwSet;
reg wrCause;
reg [15:0] wrValue;

function [15:0] mergeBytes;
    input [15:0] old;
    input [15:0] data;
    input [1:0] strb;
    begin
        mergeBytes = old;
        if (strb[0]) begin
            mergeBytes[7:0] = data[7:0];
        end
        if (strb[1]) begin
            mergeBytes[15:8] = data[15:8];
        end
    end
endfunction

always @* begin
    hwSet = 16'h0000;
    hwSet[`BIT_TRAP] = trapConflict;
    hwSet[`BIT_ILLEGAL] = illegalOpcode | uninitWregReset;
    hwSet[`BIT_DEEP_SLEEP] = sleepInstruction & deepSleepEnable;
    hwSet[`BIT_MISMATCH] = configMismatch;
    hwSet[`BIT_PIN] = masterClearPin;
    hwSet[`BIT_INSTR] = resetInstruction;
    hwSet[`BIT_WDT_TO] = watchdogTimeout;
    hwSet[`BIT_SLEEP] = sleepInstruction;
    hwSet[`BIT_IDLE] = idleInstruction;
    hwSet[`BIT_BROWNOUT] = brownoutReset;
    cause_nxt = cause_r;
    if (wrCause) begin
        // software may write any flag but deep sleep; no reset is ever triggered
        cause_nxt = wrValue;
        // deep sleep flag may only be cleared by software
        cause_nxt[`BIT_DEEP_SLEEP] = cause_r[`BIT_DEEP_SLEEP] &
            wrValue[`BIT_DEEP_SLEEP];
    end
    // a power-save instruction clears the watchdog timeout flag
    if (sleepInstruction | idleInstruction) begin
        cause_nxt[`BIT_WDT_TO] = 1'b0;
    end
    cause_nxt = (cause_nxt | hwSet) & `CAUSE_MASK;
    if (powerOnReset) begin
        cause_nxt = `CAUSE_POR_VALUE;
    end
end

// other resets only set their own flag, only power-on rewrites it
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        cause_r <= `CAUSE_POR_VALUE;
    end else begin
        cause_r <= cause_nxt;
    end
end

// ----------------------------------------
// power and watchdog outputs
// ----------------------------------------
// driven from the next status value so a write shows on the pins at the
// same edge as in the register, at the cost of a longer input path
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        watchdogEnable <= 1'b1;
        progmemBiasOn <= 1'b0;
        regulatorStandby <= 1'b1;
    end else begin
        watchdogEnable <= watchdogFuseEnable |
            cause_nxt[`BIT_WDT_EN];
        progmemBiasOn <= cause_nxt[`BIT_PM_SLEEP];
        regulatorStandby <= !cause_nxt[`BIT_PM_SLEEP];
    end
end

// ----------------------------------------
// axi4-lite slave
// ----------------------------------------
// address and data may arrive in either order; whichever comes first is
// parked until its partner is taken
reg [11:0] awAddr_r;
reg awHeld_r;
reg [31:0] wData_r;
reg [3:0] wStrb_r;
reg wHeld_r;

wire awHave = awHeld_r | (s_axi_awvalid & s_axi_awready);
wire wHave = wHeld_r | (s_axi_wvalid & s_axi_wready);
wire [11:0] awUse = awHeld_r ? awAddr_r : s_axi_awaddr;
wire [31:0] wUse = wHeld_r ? wData_r : s_axi_wdata;
wire [3:0] sUse = wHeld_r ? wStrb_r : s_axi_wstrb;
wire doWrite = awHave & wHave & !s_axi_bvalid;

always @* begin
    wrCause = doWrite && (awUse == `OFS_CAUSE_STATUS);
    wrValue = mergeBytes(cause_r, wUse[15:0], sUse[1:0]);
end

function [31:0] readWord;
    input [11:0] addr;
    input [15:0] cause;
    input [2:0] ph;
    input [15:0] dly;
    begin
        case (addr)
            `OFS_CAUSE_STATUS: readWord = {16'h0000, cause};
            `OFS_CONTROL: readWord = {29'h0, ph};
            `OFS_TIMERS: readWord = {16'h0000, dly};
            default: readWord = 32'h00000000;
        endcase
    end
endfunction

function isMapped;
    input [11:0] addr;
    begin
        isMapped = (addr == `OFS_CAUSE_STATUS) ||
            (addr == `OFS_CONTROL) || (addr == `OFS_TIMERS);
    end
endfunction

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `AXI_OKAY;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        awAddr_r <= 12'h000;
        wData_r <= 32'h00000000;
        wStrb_r <= 4'h0;
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `AXI_OKAY;
    end else begin
        // ----------------------------------------
        // write channels
        // ----------------------------------------
        if (s_axi_awvalid & s_axi_awready) begin
            awAddr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
        end
        if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= isMapped(awUse) ? `AXI_OKAY : `AXI_DECERR;
        end else begin
            awHeld_r <= awHave;
            wHeld_r <= wHave;
        end
        if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        // one write at a time: ready drops while a channel is held
        s_axi_awready <= !awHave && !doWrite && !s_axi_awready;
        s_axi_wready <= !wHave && !doWrite && !s_axi_wready;
        // ----------------------------------------
        // read channel
        // ----------------------------------------
        // status is sampled at the address edge; a flag set in the same
        // cycle shows on the next read
        s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
            s_axi_arvalid;
        if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readWord(s_axi_araddr, cause_r, phase_r, delay_r);
            s_axi_rresp <= isMapped(s_axi_araddr) ? `AXI_OKAY : `AXI_DECERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule

// ### test/reset_combiner_sva.sv
`timescale 1ns/1ps
`include "reset_combiner_regs.vh"
module reset_combiner_sva #(
    parameter PON_CYCLES = 2,
    parameter POWER_UP_TIMER_CYCLES = 2
) (
    input wire mclk,
    input wire rst,
    input wire powerOnReset,
    input wire brownoutReset,
    input wire masterClearPin,
    input wire trapConflict,
    input wire watchdogFuseEnable,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire masterSystemReset,
    input wire watchdogEnable,
    input wire progmemBiasOn,
    input wire regulatorStandby
);
    reg [11:0] rdAddr_r;
    reg [15:0] quiet_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // cycles since the last power event, saturating
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            quiet_r <= 16'h0000;
            rdAddr_r <= 12'h000;
        end else begin
            if (s_axi_arvalid && s_axi_arready) rdAddr_r <= s_axi_araddr;
            if (powerOnReset || brownoutReset) quiet_r <= 16'h0000;
            else if (quiet_r != 16'hFFFF) quiet_r <= quiet_r + 16'h0001;
        end
    end
    a_src_asserts_rst: assert property ((masterClearPin || trapConflict)
        |=> masterSystemReset) else $error("source did not assert reset");
    a_power_release: assert property ($fell(masterSystemReset)
        |-> quiet_r >= PON_CYCLES + POWER_UP_TIMER_CYCLES) else $error("early release");
    a_fuse_forces_wdt: assert property ($past(watchdogFuseEnable)
        |-> watchdogEnable) else $error("fuse did not force watchdog");
    a_bias_opposes: assert property (progmemBiasOn != regulatorStandby)
        else $error("bias and standby agree");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_write_answer: assert property (s_axi_wvalid && s_axi_wready
        |-> ##[1:4] s_axi_bvalid) else $error("no write response");
    a_gap_zero: assert property (s_axi_rvalid && rdAddr_r == 12'h000
        |-> s_axi_rdata[13:11] == 3'h0 && s_axi_rdata[31:16] == 16'h0000)
        else $error("unimplemented bits read nonzero");
    a_unmapped_decerr: assert property (s_axi_rvalid && rdAddr_r > 12'h008
        |-> s_axi_rresp == `AXI_DECERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    cover property ($fell(masterSystemReset));
    cover property (s_axi_rvalid && s_axi_rresp == `AXI_DECERR);
    cover property (trapConflict);
endmodule
bind reset_source_combiner_status reset_combiner_sva #(
    .PON_CYCLES(PON_CYCLES), .POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES)) chk (.mclk, .rst,
    .powerOnReset, .brownoutReset, .masterClearPin, .trapConflict,
    .watchdogFuseEnable, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .masterSystemReset,
    .watchdogEnable, .progmemBiasOn, .regulatorStandby);

// ### test/reset_source_model.sv
`timescale 1ns/1ps
// detectors and core: each request becomes a source level one edge later
module reset_source_model (
    input wire mclk,
    input wire rst,
    input wire [10:0] req,
    output reg [10:0] src
);
    always @(posedge mclk or posedge rst) begin
        if (rst) src <= 11'h000;
        else src <= req;
    end
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
`include "reset_combiner_regs.vh"
module testbench;
    reg mclk = 0, rst = 1, deepSleepEnable = 0, watchdogFuseEnable = 0;
    reg [10:0] req = 0;
    reg [11:0] awaddr = 0, araddr = 0;
    reg [31:0] wdata = 0, seed = 32'h8559321A, d, got;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    reg [1:0] resp;
    wire [10:0] src;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire masterSystemReset, watchdogEnable, progmemBiasOn, regulatorStandby;
    integer failures = 0, checkCount = 0, cyc = 0, i;
    always #10 mclk = ~mclk;
    reset_source_model far (.mclk(mclk), .rst(rst), .req(req), .src(src));
    reset_source_combiner_status #(.PON_CYCLES(4), .POWER_UP_TIMER_CYCLES(6)) uut (
        .mclk(mclk), .rst(rst), .powerOnReset(src[0]),
        .brownoutReset(src[1]), .masterClearPin(src[2]),
        .resetInstruction(src[3]), .watchdogTimeout(src[4]),
        .configMismatch(src[5]), .trapConflict(src[6]),
        .illegalOpcode(src[7]), .uninitWregReset(src[8]),
        .sleepInstruction(src[9]), .idleInstruction(src[10]),
        .deepSleepEnable(deepSleepEnable),
        .watchdogFuseEnable(watchdogFuseEnable),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .masterSystemReset(masterSystemReset),
        .watchdogEnable(watchdogEnable), .progmemBiasOn(progmemBiasOn),
        .regulatorStandby(regulatorStandby));
    function [31:0] rnd;
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = seed;
        end
    endfunction
    function [31:0] flagOf(input integer k);
        case (k)
            1: flagOf = 32'h0002;
            2: flagOf = 32'h0080;
            3: flagOf = 32'h0040;
            4: flagOf = 32'h0010;
            5: flagOf = 32'h0200;
            6: flagOf = 32'h8000;
            default: flagOf = 32'h4000;
        endcase
    endfunction
    task tally_and_finish;
        begin
            $display("checks %0d failures %0d", checkCount, failures);
            if (failures == 0 && checkCount > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            checkCount = checkCount + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("ERROR %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    // each bus task starts on a fresh edge so no signal is driven twice
    task wr(input [11:0] a, input [31:0] v);
        begin
            @(posedge mclk);
            awaddr <= a;
            wdata <= v;
            awvalid <= 1;
            wvalid <= 1;
            bready <= 1;
            do begin
                @(posedge mclk);
                if (awready) awvalid <= 0;
                if (wready) wvalid <= 0;
            end while (!bvalid);
            resp = bresp;
            bready <= 0;
        end
    endtask
    task rd(input [11:0] a);
        begin
            @(posedge mclk);
            araddr <= a;
            arvalid <= 1;
            rready <= 1;
            do begin
                @(posedge mclk);
                if (arready) arvalid <= 0;
            end while (!rvalid);
            got = rdata;
            resp = rresp;
            rready <= 0;
        end
    endtask
    task fire(input integer b);
        begin
            @(posedge mclk);
            req <= 11'h001 << b;
            @(posedge mclk);
            req <= 11'h000;
            repeat (4) @(posedge mclk);
            while (masterSystemReset) @(posedge mclk);
        end
    endtask
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            tally_and_finish;
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 0;
        while (masterSystemReset) @(posedge mclk);
        rd(12'h000); chk(got, 32'h0003);
        wr(12'h000, 32'h0); rd(12'h000); chk(got, 32'h0);
        for (i = 0; i < 5; i = i + 1) begin
            d = (i == 0) ? 32'hFFFFFFFF : rnd();
            wr(12'h000, d);
            chk(masterSystemReset, 0);
            rd(12'h000);
            chk(got, d & `CAUSE_MASK & 32'hFBFF);
            chk(watchdogEnable, d[5]);
            chk({progmemBiasOn, regulatorStandby}, {d[8], !d[8]});
        end
        for (i = 1; i < 9; i = i + 1) begin
            wr(12'h000, 32'h0100);
            fire(i);
            rd(12'h000);
            chk(got, 32'h0100 | flagOf(i));
        end
        deepSleepEnable <= 1;
        wr(12'h000, 32'h0010); fire(9);
        rd(12'h000); chk(got, 32'h0408);
        deepSleepEnable <= 0;
        wr(12'h000, 32'h0); wr(12'h000, 32'h0400);
        rd(12'h000); chk(got, 32'h0);
        fire(10); rd(12'h000); chk(got, 32'h0004);
        watchdogFuseEnable <= 1;
        repeat (3) @(posedge mclk);
        chk(watchdogEnable, 1);
        rd(12'h010); chk(resp, `AXI_DECERR); chk(got, 32'h0);
        wr(12'h00C, 32'hFFFF); chk(resp, `AXI_DECERR);
        rd(12'h000); chk(got, 32'h0004);
        wr(12'h000, 32'hC7F0); fire(0);
        rd(12'h000); chk(got, 32'h0003);
        tally_and_finish;
    end
endmodule
